// [logic/iqr_params.svh]
/*
 Holds the response byte positions, codes, data sizes and fixed field values
 of the inquiry responder. Assumes inclusion by bare name from logic files.
*/
`ifndef IQR_PARAMS_SVH
`define IQR_PARAMS_SVH

`define IQR_OP_INQUIRY 8'h12
`define IQR_PAGE_SUPPORTED 8'h00
`define IQR_PAGE_SERIAL 8'h80
`define IQR_LEN_STD 8'h6a
`define IQR_LEN_SUPPORTED 8'h06
`define IQR_LEN_SERIAL 8'h0e
`define IQR_STATUS_GOOD 8'h00
`define IQR_STATUS_CHECK 8'h02
`define IQR_SENSE_ILLEGAL 4'h5
`define IQR_SENSE_NONE 4'h0
`define IQR_QUAL_CONNECTED 3'h0
`define IQR_DEVTYPE_SEQ 5'h01
`define IQR_BAD_LUN 8'h7f
`define IQR_STD_BYTE1 8'h80
`define IQR_STD_BYTE2 8'h02
`define IQR_STD_BYTE3 8'h02
`define IQR_STD_ADDLEN 8'h65
`define IQR_STD_FLAGS 8'h10
`define IQR_SUP_PAGELEN 8'h02
`define IQR_SER_PAGELEN 8'h0a
`define IQR_BLANK 8'h20
`define IQR_STD_VENDOR 8'd8
`define IQR_STD_PRODUCT 8'd16
`define IQR_STD_REVISION 8'd32
`define IQR_STD_VSPEC 8'd36
`define IQR_STD_RSVD 8'd56
`define IQR_STD_SERIAL 8'd96
`define IQR_SER_OFFSET 8'd4
`define IQR_SERIAL_CHARS 10

`endif

// [logic/iqr_pkg.sv]
/*
 Holds the types shared by the inquiry responder files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package iqr_pkg;
  typedef struct packed {
    logic [7:0] opcode;
    logic [2:0] lun;
    logic [3:0] rsvd;
    logic vital_data_select;
    logic [7:0] page_code;
    logic [7:0] rsvd3;
    logic [7:0] alloc_len;
    logic [7:0] control;
  } iqr_cdb_s;

  typedef struct packed {
    logic [7:0] status;
    logic [3:0] sense_key;
  } iqr_result_s;

  typedef enum logic [1:0] {
    IQR_SEL_STD,
    IQR_SEL_SUPPORTED,
    IQR_SEL_SERIAL
  } iqr_sel_e;
endpackage

// [logic/iqr_skid_buf.sv]
/*
 Two-entry byte buffer with valid/ready on both sides.
 Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module iqr_skid_buf #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk_i,             // Clock
  input wire logic reset_i,               // Sync reset
  input wire logic [WIDTH-1:0] in_data_i, // Fill data
  input wire logic in_valid_i,            // Fill valid
  output logic in_ready_o,                // Room left
  output logic [WIDTH-1:0] out_data_o,    // Head data
  output logic out_valid_o,               // Head valid
  input wire logic out_ready_i            // Drain ready
);
  logic [WIDTH-1:0] mem_q [2];
  logic [1:0] count_q;
  logic rd_q;
  logic wr_q;
  logic push;
  logic pop;

  // Refused at elaboration, a zero-width byte lane cannot carry data
  if (WIDTH < 1) begin : g_width_check
    $error("iqr_skid_buf: WIDTH must be positive");
  end

  assign push = in_valid_i && (count_q != 2'd2);
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = (count_q != 2'd2);
  assign out_valid_o = (count_q != 2'd0);
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      count_q <= 2'd0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// [logic/iqr_responder.sv]
/*
 Inquiry command responder: decodes a six-byte command block and streams the
 selected inquiry data through a two-entry buffer, then reports status.
 Assumes the command arrives whole on one strobe and the receiver drains
 bytes with valid/ready; string fields come in as parameters.
*/
`timescale 1ns/1ps
`include "iqr_params.svh"

////////////////////////////////////////////////////////////////////////////
module iqr_responder
  import iqr_pkg::*;
#(
  parameter logic [63:0] VENDOR_ID = 64'h4142_4344_4546_4720,
  parameter logic [127:0] PRODUCT_ID = {16{8'h20}},
  parameter logic [31:0] REVISION = 32'h3030_3030,
  parameter logic [79:0] SERIAL_NO = {10{8'h20}}
) (
  input wire logic ref_clk_i,               // 100 MHz clock
  input wire logic reset_i,                 // Sync reset, active high
  input wire iqr_pkg::iqr_cdb_s cdb_i,      // Command block
  input wire logic cdb_valid_i,             // Command strobe
  input wire logic [2:0] identify_lun_i,    // Lun from identify message
  output logic busy_o,                      // Command in progress
  output logic [7:0] data_o,                // Data In byte
  output logic data_valid_o,                // Byte valid
  input wire logic data_ready_i,            // Receiver takes byte
  output iqr_pkg::iqr_result_s result_o,    // Status and sense key
  output logic done_o                       // Status pulse
);
  import iqr_pkg::*;

  typedef enum logic [1:0] {IQR_IDLE, IQR_SEND, IQR_DRAIN, IQR_DONE} iqr_st_e;

  ////////////////////////////////////////////////////////////////////////
  iqr_st_e st_q;
  iqr_sel_e sel_q;
  logic bad_lun_q;
  logic [7:0] idx_q;
  logic [7:0] count_q;
  iqr_result_s res_q;
  logic [7:0] byte_d;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [7:0] buf_out_data;
  logic push;
  logic [7:0] avail;
  logic [7:0] req_len;
  logic illegal;

  // Decode; no tape, reservation, self-test or attention input gates it
  always_comb begin
    avail = `IQR_LEN_STD;
    illegal = 1'b0;
    if (!cdb_i.vital_data_select) begin
      illegal = (cdb_i.page_code != `IQR_PAGE_SUPPORTED);
    end else if (cdb_i.page_code == `IQR_PAGE_SUPPORTED) begin
      avail = `IQR_LEN_SUPPORTED;
    end else if (cdb_i.page_code == `IQR_PAGE_SERIAL) begin
      avail = `IQR_LEN_SERIAL;
    end else begin
      illegal = 1'b1;
    end
    req_len = (cdb_i.alloc_len < avail) ? cdb_i.alloc_len : avail;
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte generator
  always_comb begin
    byte_d = 8'h00;
    unique case (sel_q)
      IQR_SEL_STD: begin
        if (idx_q == 8'd0) begin
          byte_d = bad_lun_q ? `IQR_BAD_LUN
                 : {`IQR_QUAL_CONNECTED, `IQR_DEVTYPE_SEQ};
        end else if (idx_q == 8'd1) begin
          byte_d = `IQR_STD_BYTE1;
        end else if (idx_q == 8'd2) begin
          byte_d = `IQR_STD_BYTE2;
        end else if (idx_q == 8'd3) begin
          byte_d = `IQR_STD_BYTE3;
        end else if (idx_q == 8'd4) begin
          byte_d = `IQR_STD_ADDLEN;
        end else if (idx_q == 8'd7) begin
          byte_d = `IQR_STD_FLAGS;
        end else if (idx_q < `IQR_STD_VENDOR) begin
          // Reserved 05 and 06; the vendor slice would index out of range
          byte_d = 8'h00;
        end else if (idx_q < `IQR_STD_PRODUCT) begin
          byte_d = VENDOR_ID[8'd63 - 8'd8*(idx_q - `IQR_STD_VENDOR) -: 8];
        end else if (idx_q < `IQR_STD_REVISION) begin
          byte_d = PRODUCT_ID[8'd127 - 8'd8*(idx_q - `IQR_STD_PRODUCT) -: 8];
        end else if (idx_q < `IQR_STD_VSPEC) begin
          byte_d = REVISION[8'd31 - 8'd8*(idx_q - `IQR_STD_REVISION) -: 8];
        end else if (idx_q < `IQR_STD_RSVD) begin
          byte_d = `IQR_BLANK;
        end else if (idx_q >= `IQR_STD_SERIAL) begin
          byte_d = SERIAL_NO[8'd79 - 8'd8*(idx_q - `IQR_STD_SERIAL) -: 8];
        end
      end
      IQR_SEL_SUPPORTED: begin
        unique case (idx_q)
          8'd0: byte_d = {`IQR_QUAL_CONNECTED, `IQR_DEVTYPE_SEQ};
          8'd3: byte_d = `IQR_SUP_PAGELEN;
          8'd4: byte_d = `IQR_PAGE_SUPPORTED;
          8'd5: byte_d = `IQR_PAGE_SERIAL;
          default: byte_d = 8'h00;
        endcase
      end
      IQR_SEL_SERIAL: begin
        if (idx_q == 8'd0) begin
          byte_d = bad_lun_q ? `IQR_BAD_LUN
                 : {`IQR_QUAL_CONNECTED, `IQR_DEVTYPE_SEQ};
        end else if (idx_q == 8'd1) begin
          byte_d = `IQR_PAGE_SERIAL;
        end else if (idx_q == 8'd3) begin
          byte_d = `IQR_SER_PAGELEN;
        end else if (idx_q >= `IQR_SER_OFFSET) begin
          byte_d = SERIAL_NO[8'd79 - 8'd8*(idx_q - `IQR_SER_OFFSET) -: 8];
        end
      end
      default: byte_d = 8'h00;
    endcase
  end

  assign push = (st_q == IQR_SEND) && (count_q != 8'd0);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_q <= IQR_IDLE;
      sel_q <= IQR_SEL_STD;
      bad_lun_q <= 1'b0;
      idx_q <= 8'h00;
      count_q <= 8'h00;
      res_q <= '0;
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (st_q)
        IQR_IDLE: begin
          if (cdb_valid_i && cdb_i.opcode == `IQR_OP_INQUIRY) begin
            busy_o <= 1'b1;
            idx_q <= 8'h00;
            bad_lun_q <= (cdb_i.lun != 3'd0) ||
                         (identify_lun_i != 3'd0);
            sel_q <= !cdb_i.vital_data_select ? IQR_SEL_STD
                   : (cdb_i.page_code == `IQR_PAGE_SERIAL) ? IQR_SEL_SERIAL
                   : IQR_SEL_SUPPORTED;
            if (illegal) begin
              count_q <= 8'h00;
              res_q <= '{status: `IQR_STATUS_CHECK,
                         sense_key: `IQR_SENSE_ILLEGAL};
            end else begin
              count_q <= req_len;
              res_q <= '{status: `IQR_STATUS_GOOD,
                         sense_key: `IQR_SENSE_NONE};
            end
            st_q <= IQR_SEND;
          end
        end
        IQR_SEND: begin
          if (count_q == 8'd0) begin
            st_q <= IQR_DRAIN;
          end else if (buf_in_ready) begin
            idx_q <= idx_q + 8'd1;
            count_q <= count_q - 8'd1;
          end
        end
        IQR_DRAIN: begin
          // Status only after the last byte has left the buffer
          if (!buf_out_valid && !data_valid_o) begin
            st_q <= IQR_DONE;
          end
        end
        IQR_DONE: begin
          done_o <= 1'b1;
          busy_o <= 1'b0;
          st_q <= IQR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      result_o <= '0;
    end else if (st_q == IQR_DONE) begin
      result_o <= res_q; // Unit attention state lives elsewhere
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output register after the buffer keeps data_o flop-driven
  logic out_take;
  assign out_take = buf_out_valid && (!data_valid_o || data_ready_i);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      data_valid_o <= 1'b0;
      data_o <= 8'h00;
    end else if (!data_valid_o || data_ready_i) begin
      data_valid_o <= buf_out_valid;
      if (buf_out_valid) data_o <= buf_out_data;
    end
  end

  iqr_skid_buf #(.WIDTH(8)) u_buf (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .in_data_i(byte_d),
    .in_valid_i(push),
    .in_ready_o(buf_in_ready),
    .out_data_o(buf_out_data),
    .out_valid_o(buf_out_valid),
    .out_ready_i(out_take)
  );
endmodule

// [sim/iqr_responder_properties.sv]
/*
 Concurrent checks on the inquiry responder ports, bound to iqr_responder.
 Assumes iqr_pkg is compiled first and one clock domain.
*/
`timescale 1ns/1ps
module iqr_responder_properties
  import iqr_pkg::*;
(
  input wire logic ref_clk_i,                // Clock
  input wire logic reset_i,                  // Sync reset
  input wire iqr_pkg::iqr_cdb_s cdb_i,       // Command block
  input wire logic cdb_valid_i,              // Command strobe
  input wire logic [2:0] identify_lun_i,     // Identify lun
  input wire logic busy_o,                   // Busy
  input wire logic [7:0] data_o,             // Data byte
  input wire logic data_valid_o,             // Byte valid
  input wire logic data_ready_i,             // Byte taken
  input wire iqr_pkg::iqr_result_s result_o, // Status
  input wire logic done_o                    // Done pulse
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic take, legal;
  logic [7:0] avail, cnt_q, lim_q;
  assign take = cdb_valid_i && !busy_o && cdb_i.opcode == 8'h12;
  assign legal = cdb_i.page_code == 8'h00 ||
    (cdb_i.vital_data_select && cdb_i.page_code == 8'h80);
  assign avail = !cdb_i.vital_data_select ? 8'h6a :
    (cdb_i.page_code == 8'h80) ? 8'h0e : 8'h06;
  // Byte count per command, compared with the expected limit at done
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || take) cnt_q <= 8'h00;
    else if (data_valid_o && data_ready_i) cnt_q <= cnt_q + 8'h01;
  end
  always_ff @(posedge ref_clk_i) begin
    if (take) lim_q <= !legal ? 8'h00 :
      (cdb_i.alloc_len < avail) ? cdb_i.alloc_len : avail;
  end
  ////////////////////////////////////////////////////////////////////////
  busy_on_take_a: assert property (take |=> busy_o)
    else $error("Inquiry strobe did not raise busy");
  other_op_a: assert property (
    cdb_valid_i && !busy_o && cdb_i.opcode != 8'h12 |=> !busy_o)
    else $error("Foreign opcode started a command");
  zero_len_a: assert property (
    take && cdb_i.alloc_len == 8'h00 && legal |=> !data_valid_o
    throughout ##[1:12] (done_o && result_o == 12'h000))
    else $error("Zero length sent data or failed");
  illegal_page_a: assert property (
    take && !legal |=> !data_valid_o
    throughout ##[1:12] (done_o && result_o == 12'h025))
    else $error("Bad page not refused");
  stall_hold_a: assert property (
    data_valid_o && !data_ready_i |=> data_valid_o && $stable(data_o))
    else $error("Byte lost during stall");
  done_pulse_a: assert property (done_o |-> !busy_o ##1 !done_o)
    else $error("Done not a single pulse");
  status_code_a: assert property (
    done_o |-> result_o == 12'h000 || result_o == 12'h025)
    else $error("Bad status or sense code");
  result_hold_a: assert property (!done_o |-> $stable(result_o))
    else $error("Result moved without done");
  byte_count_a: assert property (done_o |-> cnt_q == lim_q)
    else $error("Wrong number of bytes sent");
  cover property (take && cdb_i.page_code == 8'h80);
  cover property (data_valid_o && !data_ready_i);
  cover property (done_o && result_o.status == 8'h02);
endmodule

bind iqr_responder iqr_responder_properties i_iqr_responder_properties (
  .ref_clk_i, .reset_i, .cdb_i, .cdb_valid_i, .identify_lun_i, .busy_o,
  .data_o, .data_valid_o, .data_ready_i, .result_o, .done_o);

// [sim/iqr_receiver.sv]
/*
 Initiator side model: takes Data In bytes with random stalls and queues them.
 Assumes the bench seeds the random generator.
*/
`timescale 1ns/1ps
module iqr_receiver (
  input wire logic ref_clk_i,      // Clock
  input wire logic reset_i,        // Sync reset
  input wire logic [7:0] data_i,   // Data In byte
  input wire logic valid_i,        // Byte valid
  input wire logic [1:0] stall_i,  // Stall level, 0 never stalls
  output logic ready_o = 1'b0      // Takes byte
);
  logic [7:0] rx_q[$];
  always @(posedge ref_clk_i) begin
    if (reset_i) ready_o <= 1'b0;
    else begin
      if (valid_i && ready_o) rx_q.push_back(data_i);
      ready_o <= $urandom_range(3) >= stall_i;
    end
  end
endmodule

// [sim/test_inquiry_command_responder.sv]
/*
 Self-checking bench for the inquiry responder with a stalling receiver.
 Assumes iqr_pkg, the design files and iqr_receiver are compiled first.
*/
`timescale 1ns/1ps
module test_inquiry_command_responder;
  import iqr_pkg::*;
  localparam logic [63:0] VEN = 64'h5445_5354_5645_4e20; // Arbitrary text
  localparam logic [127:0] PRD = {8{16'h5a59}};
  localparam logic [31:0] REV = 32'h3132_3334;
  localparam logic [79:0] SER = 80'h3938_3736_3534_2020_2020;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  iqr_cdb_s cdb_i = '0;
  logic cdb_valid_i = 1'b0;
  logic [2:0] identify_lun_i = 3'h0;
  logic busy_o, data_valid_o, data_ready_i, done_o, vds;
  logic [7:0] data_o, pg;
  iqr_result_s result_o;
  logic [1:0] stall = 2'd3;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  iqr_responder #(.VENDOR_ID(VEN), .PRODUCT_ID(PRD), .REVISION(REV),
    .SERIAL_NO(SER)) i_iqr_responder (.ref_clk_i, .reset_i, .cdb_i,
    .cdb_valid_i, .identify_lun_i, .busy_o, .data_o, .data_valid_o,
    .data_ready_i, .result_o, .done_o);
  iqr_receiver i_iqr_receiver (.ref_clk_i, .reset_i, .data_i(data_o),
    .valid_i(data_valid_o), .stall_i(stall), .ready_o(data_ready_i));
  always #5 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Ceiling well above the slowest stalled run
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] exp_byte(int sel, int i, bit bad);
    logic [7:0] b0;
    logic [55:0] hd;
    b0 = bad ? 8'h7f : 8'h01;
    hd = 56'h80_0202_6500_0010;
    if (sel == 1) return i == 0 ? 8'h01 : i == 3 ? 8'h02 :
      i == 5 ? 8'h80 : 8'h00;
    if (sel == 2 && i < 4) return i == 0 ? b0 : i == 1 ? 8'h80 :
      i == 3 ? 8'h0a : 8'h00;
    if (sel == 2) return SER[8*(13-i) +: 8];
    if (i == 0) return b0;
    if (i < 8) return hd[8*(7-i) +: 8];
    if (i < 16) return VEN[8*(15-i) +: 8];
    if (i < 32) return PRD[8*(31-i) +: 8];
    if (i < 36) return REV[8*(35-i) +: 8];
    if (i < 56) return 8'h20;
    if (i < 96) return 8'h00;
    return SER[8*(105-i) +: 8];
  endfunction
  // One command, then the received bytes and status against the model
  task automatic run_cmd(input logic [7:0] op, input logic [2:0] lun,
    input logic sel_vpd, input logic [7:0] page, input logic [7:0] len,
    input logic [2:0] il);
    int sel, n, k, lim;
    bit ill;
    ill = sel_vpd ? (page != 8'h00 && page != 8'h80) : (page != 8'h00);
    sel = !sel_vpd ? 0 : (page == 8'h80) ? 2 : 1;
    n = sel == 0 ? 106 : sel == 1 ? 6 : 14;
    if (len < n) n = len;
    if (ill || op != 8'h12) n = 0;
    lim = (op == 8'h12) ? 2000 : 12;
    i_iqr_receiver.rx_q.delete();
    @(posedge ref_clk_i);
    cdb_i <= '{op, lun, 4'h0, sel_vpd, page, 8'h00, len, 8'h00};
    identify_lun_i <= il;
    cdb_valid_i <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      cdb_valid_i <= (k == 2 && n > 3); // Strobe while busy is dropped
      #1;
      k++;
    end while (done_o !== 1'b1 && k < lim);
    check(done_o, op == 8'h12);
    check(i_iqr_receiver.rx_q.size(), n);
    if (op == 8'h12) check(result_o, ill ? 12'h025 : 12'h000);
    for (int i = 0; i < n; i++)
      check(i_iqr_receiver.rx_q[i],
        exp_byte(sel, i, lun != 3'h0 || il != 3'h0));
  endtask
  initial begin
    void'($urandom(45));
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    check({busy_o, data_valid_o, done_o, result_o, data_o}, 0);
    run_cmd(8'h12, 3'h0, 1'b0, 8'h00, 8'hff, 3'h0);
    run_cmd(8'h12, 3'h0, 1'b0, 8'h00, 8'h00, 3'h0);
    run_cmd(8'h12, 3'h0, 1'b0, 8'h00, 8'h07, 3'h0);
    run_cmd(8'h12, 3'h0, 1'b1, 8'h00, 8'h06, 3'h0);
    run_cmd(8'h12, 3'h0, 1'b1, 8'h00, 8'hff, 3'h0);
    run_cmd(8'h12, 3'h0, 1'b1, 8'h80, 8'h0e, 3'h0);
    run_cmd(8'h12, 3'h0, 1'b1, 8'h80, 8'h05, 3'h0);
    run_cmd(8'h12, 3'h1, 1'b0, 8'h00, 8'hff, 3'h0);
    run_cmd(8'h12, 3'h0, 1'b1, 8'h80, 8'h0e, 3'h4);
    run_cmd(8'h12, 3'h0, 1'b0, 8'h80, 8'hff, 3'h0);
    run_cmd(8'h12, 3'h0, 1'b1, 8'h81, 8'hff, 3'h0);
    run_cmd(8'h19, 3'h0, 1'b0, 8'h00, 8'hff, 3'h0);
    repeat (16) begin
      vds = 1'($urandom_range(1));
      pg = $urandom_range(1) ? 8'h80 : 8'h00;
      stall <= 2'($urandom_range(3));
      run_cmd(8'h12, 3'($urandom_range(7) / 6), vds, pg,
        8'($urandom_range(255)), 3'h0);
    end
    complete_run();
  end
endmodule
